/* logic/dqp_ctrl_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - start address is field times four plus base
// - write address is field times four plus base
// - read address is field times four plus base
// - end address is field times four plus base
// - any control write with a byte enable updates every bit
// - control untouched when no byte enables
// - enable lets engine take ready references
// - disabled: ready queue ignored, nothing taken
// - disabled: drain built lists, then stop
// - cache on: free writes in blocks of six
// - cache off: one free write per reference
// - ready interrupt after selected read count
// - free interrupt after selected free-write count
module dqp_ctrl_top
  import dqp_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic [31:0] S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [31:0] S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic [31:0] RX_QUEUE_BASE_IN,
  input  wire logic        READY_REF_TAKEN_IN,
  input  wire logic        REF_FREED_IN,
  input  wire logic        LISTS_PENDING_IN,
  output logic [31:0]      READY_START_ADDR_OUT,
  output logic [31:0]      READY_WRITE_ADDR_OUT,
  output logic [31:0]      READY_READ_ADDR_OUT,
  output logic [31:0]      READY_END_ADDR_OUT,
  output logic             READY_FETCH_EN_OUT,
  output logic             TX_LINK_ACTIVE_OUT,
  output logic             FREE_WRITE_OUT,
  output logic [2:0]       FREE_WRITE_COUNT_OUT,
  output logic             READY_IRQ_OUT,
  output logic             FREE_IRQ_OUT
);

  // ****************************************************
  // declarations
  // ****************************************************
  logic [15:0] start_ff;
  logic [15:0] wptr_ff;
  logic [15:0] rptr_ff;
  logic [15:0] eptr_ff;
  logic [6:0]  ctl_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        wr_do;
  dqp_sel_type wr_sel;
  dqp_sel_type rd_sel;
  logic        rd_take;
  logic [31:0] nxt_rdata;
  logic [2:0]  cache_cnt_ff;
  logic [2:0]  nxt_cache_cnt;
  logic        nxt_free_wr;
  logic [2:0]  nxt_free_cnt;
  logic        rdy_evt;
  logic        en;
  logic        cache_on;

  assign en       = ctl_ff[DQP_CTL_EN_POS];
  assign cache_on = ctl_ff[DQP_CTL_CACHE_POS];

  // ****************************************************
  // write address and data channels
  // ****************************************************
  assign wr_do  = aw_got_ff && w_got_ff && !S_AXI_BVALID_OUT;
  assign wr_sel = dqp_decode(awaddr_ff);

  // address accepted once per write, either order with data
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      S_AXI_AWREADY_OUT <= 1'b0;
      aw_got_ff         <= 1'b0;
      awaddr_ff         <= 32'h00000000;
    end else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      S_AXI_AWREADY_OUT <= 1'b0;
      aw_got_ff         <= 1'b1;
      awaddr_ff         <= S_AXI_AWADDR_IN;
    end else begin
      S_AXI_AWREADY_OUT <= S_AXI_AWVALID_IN && !aw_got_ff &&
                           !S_AXI_BVALID_OUT;
      if (wr_do) begin
        aw_got_ff <= 1'b0;
      end
    end
  end

  // data accepted once per write
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      S_AXI_WREADY_OUT <= 1'b0;
      w_got_ff         <= 1'b0;
      wdata_ff         <= 32'h00000000;
      wstrb_ff         <= 4'h0;
    end else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      S_AXI_WREADY_OUT <= 1'b0;
      w_got_ff         <= 1'b1;
      wdata_ff         <= S_AXI_WDATA_IN;
      wstrb_ff         <= S_AXI_WSTRB_IN;
    end else begin
      S_AXI_WREADY_OUT <= S_AXI_WVALID_IN && !w_got_ff &&
                          !S_AXI_BVALID_OUT;
      if (wr_do) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // write response, error for unmapped address
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= DQP_RESP_OKAY;
    end else if (wr_do) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT  <= (wr_sel == DQP_SEL_NONE) ? DQP_RESP_SLVERR
                                                   : DQP_RESP_OKAY;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // ****************************************************
  // register storage
  // ****************************************************
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      start_ff <= DQP_PTR_RST;
      wptr_ff  <= DQP_PTR_RST;
      rptr_ff  <= DQP_PTR_RST;
      eptr_ff  <= DQP_PTR_RST;
    end else if (wr_do) begin
      case (wr_sel)
        DQP_SEL_START: start_ff <= merge16(start_ff, wdata_ff, wstrb_ff);
        DQP_SEL_WRITE: wptr_ff  <= merge16(wptr_ff, wdata_ff, wstrb_ff);
        DQP_SEL_READ:  rptr_ff  <= merge16(rptr_ff, wdata_ff, wstrb_ff);
        DQP_SEL_END:   eptr_ff  <= merge16(eptr_ff, wdata_ff, wstrb_ff);
        default: ;
      endcase
    end
  end

  // control: whole word or nothing, no lane select
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      ctl_ff <= DQP_CTL_RST;
    end else if (wr_do && (wr_sel == DQP_SEL_CTL) &&
                 (wstrb_ff != 4'h0)) begin
      ctl_ff <= wdata_ff[DQP_CTL_W-1:0];
    end
  end

  // ****************************************************
  // read channel
  // ****************************************************
  assign rd_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  assign rd_sel  = dqp_decode(S_AXI_ARADDR_IN);

  // read data mux, upper bits read as zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    case (rd_sel)
      DQP_SEL_START: nxt_rdata[15:0] = start_ff;
      DQP_SEL_WRITE: nxt_rdata[15:0] = wptr_ff;
      DQP_SEL_READ:  nxt_rdata[15:0] = rptr_ff;
      DQP_SEL_END:   nxt_rdata[15:0] = eptr_ff;
      DQP_SEL_CTL:   nxt_rdata[DQP_CTL_W-1:0] = ctl_ff;
      default:       nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
    end else begin
      S_AXI_ARREADY_OUT <= S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT &&
                           !S_AXI_RVALID_OUT;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= 32'h00000000;
      S_AXI_RRESP_OUT  <= DQP_RESP_OKAY;
    end else if (rd_take) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RDATA_OUT  <= nxt_rdata;
      S_AXI_RRESP_OUT  <= (rd_sel == DQP_SEL_NONE) ? DQP_RESP_SLVERR
                                                   : DQP_RESP_OKAY;
    end else if (S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // ****************************************************
  // physical queue addresses
  // ****************************************************
  // base plus word offset, one cycle late
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      READY_START_ADDR_OUT <= 32'h00000000;
      READY_WRITE_ADDR_OUT <= 32'h00000000;
      READY_READ_ADDR_OUT  <= 32'h00000000;
      READY_END_ADDR_OUT   <= 32'h00000000;
    end else begin
      READY_START_ADDR_OUT <= phys(start_ff, RX_QUEUE_BASE_IN);
      READY_WRITE_ADDR_OUT <= phys(wptr_ff, RX_QUEUE_BASE_IN);
      READY_READ_ADDR_OUT  <= phys(rptr_ff, RX_QUEUE_BASE_IN);
      READY_END_ADDR_OUT   <= phys(eptr_ff, RX_QUEUE_BASE_IN);
    end
  end

  // ****************************************************
  // transmit enable and link activity
  // ****************************************************
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      READY_FETCH_EN_OUT <= 1'b0;
      TX_LINK_ACTIVE_OUT <= 1'b0;
    end else begin
      READY_FETCH_EN_OUT <= en;
      TX_LINK_ACTIVE_OUT <= en || LISTS_PENDING_IN;
    end
  end

  // ready references counted only while enabled
  assign rdy_evt = READY_REF_TAKEN_IN && en;

  // ****************************************************
  // free reference cache
  // ****************************************************
  always_comb begin
    nxt_cache_cnt = cache_cnt_ff;
    nxt_free_wr   = 1'b0;
    nxt_free_cnt  = 3'h0;
    if (cache_on) begin
      if (REF_FREED_IN) begin
        if (cache_cnt_ff + DQP_ONE_REF == DQP_CACHE_BLOCK) begin
          nxt_free_wr   = 1'b1;
          nxt_free_cnt  = DQP_CACHE_BLOCK;
          nxt_cache_cnt = 3'h0;
        end else begin
          nxt_cache_cnt = cache_cnt_ff + DQP_ONE_REF;
        end
      end
    end else if (REF_FREED_IN) begin
      nxt_free_wr   = 1'b1;
      nxt_free_cnt  = cache_cnt_ff + DQP_ONE_REF;
      nxt_cache_cnt = 3'h0;
    end else if (cache_cnt_ff != 3'h0) begin
      nxt_free_wr   = 1'b1;                           // leftovers flushed
      nxt_free_cnt  = cache_cnt_ff;
      nxt_cache_cnt = 3'h0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      cache_cnt_ff         <= 3'h0;
      FREE_WRITE_OUT       <= 1'b0;
      FREE_WRITE_COUNT_OUT <= 3'h0;
    end else begin
      cache_cnt_ff         <= nxt_cache_cnt;
      FREE_WRITE_OUT       <= nxt_free_wr;
      FREE_WRITE_COUNT_OUT <= nxt_free_cnt;
    end
  end

  // ****************************************************
  // interrupt threshold counters
  // ****************************************************
  dqp_thr_cnt #(.CNT_W(DQP_THR_W)) u_rdy_cnt (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .evt_in    (rdy_evt),
    .thr_in    (dqp_rdy_count(ctl_ff[DQP_CTL_RDY_LSB +: 3])),
    .irq_out   (READY_IRQ_OUT)
  );
  dqp_thr_cnt #(.CNT_W(DQP_THR_W)) u_frn_cnt (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .evt_in    (nxt_free_wr),
    .thr_in    (dqp_frn_count(ctl_ff[DQP_CTL_FRN_LSB +: 2])),
    .irq_out   (FREE_IRQ_OUT)
  );

  // ****************************************************
  // checks
  // ****************************************************
  start_addr_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    READY_START_ADDR_OUT ==
      $past(RX_QUEUE_BASE_IN) + {14'h0000, $past(start_ff), 2'h0})
    else $error("start address not base plus field");
  write_addr_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    wr_do && wr_sel == DQP_SEL_WRITE && wstrb_ff == 4'hf
    |=> ##1 READY_WRITE_ADDR_OUT ==
        $past(RX_QUEUE_BASE_IN) + {14'h0000, $past(wdata_ff[15:0], 2),
                                   2'h0})
    else $error("write address not base plus field");
  read_addr_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    READY_READ_ADDR_OUT ==
      $past(RX_QUEUE_BASE_IN) + {14'h0000, $past(rptr_ff), 2'h0})
    else $error("read address not base plus field");
  end_addr_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    READY_END_ADDR_OUT ==
      $past(RX_QUEUE_BASE_IN) + {14'h0000, $past(eptr_ff), 2'h0})
    else $error("end address not base plus field");
  ctl_whole_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    wr_do && wr_sel == DQP_SEL_CTL && wstrb_ff != 4'h0
    |=> ctl_ff == $past(wdata_ff[6:0]))
    else $error("control write did not update all bits");
  ctl_nolane_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    wr_do && wr_sel == DQP_SEL_CTL && wstrb_ff == 4'h0
    |=> $stable(ctl_ff))
    else $error("control changed with no byte enables");
  fetch_en_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $rose(en) |=> READY_FETCH_EN_OUT)
    else $error("fetch enable did not follow control");
  ready_ignored_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !en |=> !READY_IRQ_OUT && !READY_FETCH_EN_OUT)
    else $error("ready queue used while disabled");
  link_drain_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !en && !LISTS_PENDING_IN |=> !TX_LINK_ACTIVE_OUT)
    else $error("link active after lists used up");
  cache_block_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    cache_on && REF_FREED_IN && cache_cnt_ff == 3'h5
    |=> FREE_WRITE_OUT && FREE_WRITE_COUNT_OUT == 3'h6 &&
        cache_cnt_ff == 3'h0)
    else $error("cache did not write a block of six");
  single_free_a:
  assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !cache_on && REF_FREED_IN && cache_cnt_ff == 3'h0
    |=> FREE_WRITE_OUT && FREE_WRITE_COUNT_OUT == 3'h1)
    else $error("uncached reference not written alone");

endmodule

/* logic/dqp_pkg.sv */
package dqp_pkg;

  // ****************************************************
  // register map (byte addresses)
  // ****************************************************
  localparam logic [11:0] DQP_OFS_START = 12'h2b8;
  localparam logic [11:0] DQP_OFS_WRITE = 12'h2bc;
  localparam logic [11:0] DQP_OFS_READ  = 12'h2c0;
  localparam logic [11:0] DQP_OFS_END   = 12'h2c4;
  localparam logic [11:0] DQP_OFS_CTL   = 12'h300;

  // ****************************************************
  // control fields and reset values
  // ****************************************************
  localparam int DQP_CTL_EN_POS   = 0;
  localparam int DQP_CTL_CACHE_POS = 1;
  localparam int DQP_CTL_RDY_LSB  = 2;
  localparam int DQP_CTL_FRN_LSB  = 5;
  localparam int DQP_CTL_W        = 7;
  localparam logic [6:0]  DQP_CTL_RST = 7'h02;
  localparam logic [15:0] DQP_PTR_RST = 16'h0000;
  localparam int DQP_PTR_SHIFT    = 2;

  // ****************************************************
  // free reference cache and thresholds
  // ****************************************************
  localparam logic [2:0] DQP_CACHE_BLOCK = 3'h6;
  localparam logic [2:0] DQP_ONE_REF     = 3'h1;
  localparam int DQP_THR_W = 6;

  // ****************************************************
  // bus answers
  // ****************************************************
  localparam logic [1:0] DQP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DQP_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    DQP_SEL_START = 3'h0,
    DQP_SEL_WRITE = 3'h1,
    DQP_SEL_READ  = 3'h3,
    DQP_SEL_END   = 3'h2,
    DQP_SEL_CTL   = 3'h6,
    DQP_SEL_NONE  = 3'h7
  } dqp_sel_type;

  // address decode shared by read and write paths
  function automatic dqp_sel_type dqp_decode(input logic [31:0] addr);
    case (addr[11:0])
      DQP_OFS_START: dqp_decode = DQP_SEL_START;
      DQP_OFS_WRITE: dqp_decode = DQP_SEL_WRITE;
      DQP_OFS_READ:  dqp_decode = DQP_SEL_READ;
      DQP_OFS_END:   dqp_decode = DQP_SEL_END;
      DQP_OFS_CTL:   dqp_decode = DQP_SEL_CTL;
      default:       dqp_decode = DQP_SEL_NONE;
    endcase
    if (addr[31:12] != 20'h00000) begin
      dqp_decode = DQP_SEL_NONE;
    end
  endfunction

  // ready threshold code to count, reserved codes take the largest
  function automatic logic [5:0] dqp_rdy_count(input logic [2:0] code);
    case (code)
      3'h0:    dqp_rdy_count = 6'h01;
      3'h1:    dqp_rdy_count = 6'h04;
      3'h2:    dqp_rdy_count = 6'h06;
      3'h3:    dqp_rdy_count = 6'h08;
      3'h4:    dqp_rdy_count = 6'h10;
      default: dqp_rdy_count = 6'h20;
    endcase
  endfunction

  // free threshold code to count, reserved code takes the largest
  function automatic logic [5:0] dqp_frn_count(input logic [1:0] code);
    case (code)
      2'h0:    dqp_frn_count = 6'h01;
      2'h1:    dqp_frn_count = 6'h04;
      default: dqp_frn_count = 6'h08;
    endcase
  endfunction

  // byte-lane merge for the 16-bit pointer fields
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  // pointer word offset to physical address
  function automatic logic [31:0] phys(input logic [15:0] fld,
                                       input logic [31:0] base);
    phys = base + {14'h0000, fld, 2'h0};
  endfunction

endpackage

/* logic/dqp_thr_cnt.sv */
`timescale 1ns/1ps
module dqp_thr_cnt
  import dqp_pkg::*;
#(
  parameter int CNT_W = DQP_THR_W
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             evt_in,
  input  wire logic [CNT_W-1:0] thr_in,
  output logic                  irq_out
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             hit;

  initial begin
    if (CNT_W < 6) begin
      $error("dqp_thr_cnt: CNT_W must hold a count of 32");
    end
  end

  // ****************************************************
  // event counter against threshold
  // ****************************************************
  assign nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
  assign hit     = evt_in && (nxt_cnt >= thr_in);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_ff <= '0;
    end else if (hit) begin
      cnt_ff <= '0;
    end else if (evt_in) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // one-cycle interrupt pulse
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= hit;
    end
  end

  thr_hit_a:
  assert property (@(posedge clk_in) disable iff (!resetn_in)
    evt_in && (nxt_cnt >= thr_in) |=> irq_out && (cnt_ff == '0))
    else $error("threshold reached without interrupt");

  thr_quiet_a:
  assert property (@(posedge clk_in) disable iff (!resetn_in)
    !evt_in |=> !irq_out && $stable(cnt_ff))
    else $error("interrupt or count moved without event");

endmodule

/* sim/dma_queue_pointer_and_tx_control_bench.sv */
`timescale 1ns/1ps
module dma_queue_pointer_and_tx_control_bench;
  import dqp_pkg::*;
  logic             clk, rst_n, awv, wv, bready, arv, rready;
  logic [31:0]      awaddr, wdata, araddr, base, d, e;
  logic [3:0]       wstrb;
  logic [1:0]       rsp;
  wire logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, taken, freed, pend;
  wire logic        fetch_en, link_act, fw, r_irq, f_irq;
  wire logic [1:0]  b_resp, r_resp;
  wire logic [2:0]  fw_cnt;
  wire logic [31:0] r_data;
  wire logic [31:0] ptr_addr [4];
  int n_mismatch, compares, seed, n_rirq, n_firq, n_fw, n_fref;
  int rdy_tab [8] = '{1, 4, 6, 8, 16, 32, 32, 32};
  int frn_tab [4] = '{1, 4, 8, 8};
  logic [11:0] ofs [4] = '{DQP_OFS_START, DQP_OFS_WRITE, DQP_OFS_READ,
                           DQP_OFS_END};

  // ********
  // design and engine stand-in
  // ********
  dqp_ctrl_top i_dut (
    .CLK_IN(clk), .RESETN_IN(rst_n),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(aw_rdy), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(w_rdy),
    .S_AXI_BRESP_OUT(b_resp), .S_AXI_BVALID_OUT(b_v),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(ar_rdy),
    .S_AXI_RDATA_OUT(r_data), .S_AXI_RRESP_OUT(r_resp),
    .S_AXI_RVALID_OUT(r_v), .S_AXI_RREADY_IN(rready),
    .RX_QUEUE_BASE_IN(base), .READY_REF_TAKEN_IN(taken),
    .REF_FREED_IN(freed), .LISTS_PENDING_IN(pend),
    .READY_START_ADDR_OUT(ptr_addr[0]), .READY_WRITE_ADDR_OUT(ptr_addr[1]),
    .READY_READ_ADDR_OUT(ptr_addr[2]), .READY_END_ADDR_OUT(ptr_addr[3]),
    .READY_FETCH_EN_OUT(fetch_en), .TX_LINK_ACTIVE_OUT(link_act),
    .FREE_WRITE_OUT(fw), .FREE_WRITE_COUNT_OUT(fw_cnt),
    .READY_IRQ_OUT(r_irq), .FREE_IRQ_OUT(f_irq));
  dqp_eng_model i_eng (.clk_in(clk), .taken_out(taken), .freed_out(freed),
                       .pending_out(pend));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // tally interrupt and free-write pulses
  always @(posedge clk) begin
    if (rst_n === 1'b1) begin
      if (r_irq !== 1'b0) n_rirq++;
      if (f_irq !== 1'b0) n_firq++;
      if (fw !== 1'b0) begin
        n_fw++;
        n_fref += int'(fw_cnt);
      end
    end
  end

  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one write: address and data offered together, held until taken
  task automatic axw(input logic [31:0] a, input logic [31:0] v,
                     input logic [3:0] s);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_rdy === 1'b1) awv <= 1'b0;
      if (w_rdy === 1'b1) wv <= 1'b0;
    end while (b_v !== 1'b1);
    rsp = b_resp;
    bready <= 1'b0;
    @(posedge clk); // let an edge pass before the next request
  endtask

  task automatic axr(input logic [31:0] a);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_rdy === 1'b1) arv <= 1'b0;
    end while (r_v !== 1'b1);
    d = r_data;
    rsp = r_resp;
    rready <= 1'b0;
    @(posedge clk); // let an edge pass before the next request
  endtask

  function automatic logic [31:0] ctl(input int f, input int r,
                                      input int c, input int en);
    return {25'h0, f[1:0], r[2:0], c[0], en[0]};
  endfunction

  function automatic int gap();
    return 1 + ($random(seed) & 3);
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    seed = 66540;
    {rst_n, awv, wv, bready, arv, rready} = 6'h00;
    {awaddr, wdata, araddr, base, wstrb} = 132'h0;
    {n_mismatch, compares, n_rirq, n_firq, n_fw, n_fref} = '0;
    wt(16);
    rst_n <= 1'b1;
    wt(1);
    axr(32'h300);
    chk(d, 32'h2);
    for (int i = 0; i < 4; i++) begin
      axr({20'h0, ofs[i]});
      chk(d, 32'h0);
    end
    axr(32'h400);
    chk({d[31:2], rsp}, {30'h0, DQP_RESP_SLVERR});
    axw(32'h1300, 32'hffff, 4'hf);
    chk({30'h0, rsp}, {30'h0, DQP_RESP_SLVERR});
    // pointer fields, last pass at the top corner
    for (int i = 0; i < 5; i++) begin
      base <= (i == 4) ? 32'hffff_fffc : $random(seed);
      e = (i == 4) ? 32'hffff_ffff : $random(seed);
      axw({20'h0, ofs[i % 4]}, e, i[0] ? 4'hf : 4'h3);
      axr({20'h0, ofs[i % 4]});
      chk(d, {16'h0, e[15:0]});
      chk(ptr_addr[i % 4], base + {14'h0, e[15:0], 2'h0});
    end
    axw(32'h300, ctl(0, 0, 1, 1), 4'h8);
    axr(32'h300);
    chk(d, 32'h3);
    axw(32'h300, 32'h7c, 4'h0);
    axr(32'h300);
    chk(d, 32'h3);
    chk(fetch_en, 32'h1);
    i_eng.set_pending(1'b1);
    axw(32'h300, ctl(0, 0, 1, 0), 4'hf);
    wt(2);
    chk(fetch_en, 32'h0);
    chk(link_act, 32'h1);
    i_eng.set_pending(1'b0);
    wt(2);
    chk(link_act, 32'h0);
    n_rirq = 0;
    i_eng.pulse(1'b0, 5, gap());
    wt(3);
    chk(n_rirq, 32'h0);
    // every ready threshold code, reserved ones too
    for (int c = 0; c < 8; c++) begin
      axw(32'h300, ctl(0, c, 1, 1), 4'hf);
      n_rirq = 0;
      i_eng.pulse(1'b0, rdy_tab[c], gap());
      wt(3);
      chk(n_rirq, 32'h1);
    end
    {n_fw, n_fref, n_firq} = '0;
    i_eng.pulse(1'b1, 6, gap());
    wt(3);
    chk(n_fw, 32'h1);
    chk(n_fref, 32'h6);
    chk(n_firq, 32'h1);
    // two cached references flushed when the cache is turned off
    i_eng.pulse(1'b1, 2, gap());
    axw(32'h300, ctl(0, 0, 0, 1), 4'hf);
    wt(3);
    chk(n_fw, 32'h2);
    chk(n_fref, 32'h8);
    chk(n_firq, 32'h2);
    // every free threshold code with the cache off
    for (int f = 0; f < 4; f++) begin
      axw(32'h300, ctl(f, 0, 0, 1), 4'hf);
      {n_fw, n_fref, n_firq} = '0;
      i_eng.pulse(1'b1, frn_tab[f], gap());
      wt(3);
      chk(n_fw, frn_tab[f]);
      chk(n_fref, frn_tab[f]);
      chk(n_firq, 32'h1);
    end
    wrap_up();
  end

  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    #1000000;
    n_mismatch++;
    wrap_up();
  end
endmodule

/* sim/dqp_eng_model.sv */
`timescale 1ns/1ps
// ********
// transmit engine stand-in
// ********
module dqp_eng_model (
  input  wire logic clk_in,
  output logic      taken_out,
  output logic      freed_out,
  output logic      pending_out
);
  // idle until the bench asks for events
  initial begin
    taken_out = 1'b0;
    freed_out = 1'b0;
    pending_out = 1'b0;
  end

  // one-cycle event pulses with a gap of at least one cycle
  task automatic pulse(input bit sel, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      if (sel) freed_out <= 1'b1;
      else taken_out <= 1'b1;
      @(posedge clk_in);
      taken_out <= 1'b0;
      freed_out <= 1'b0;
      repeat (gap) @(posedge clk_in);
    end
  endtask

  // built lists still holding work
  task automatic set_pending(input bit b);
    pending_out <= b;
  endtask
endmodule
